// >>> asf_map.svh
// asf_map.svh: register offsets, field positions and timing counts for the
// strobe fifo controller. assumes a 100 MHz clk; included by bare name.
`ifndef ASF_MAP_SVH
`define ASF_MAP_SVH
// register byte offsets
`define ASF_REG_CTRL        12'h000
`define ASF_REG_WDATA       12'h004
`define ASF_REG_RDATA       12'h008
`define ASF_REG_STATUS      12'h00C
// control fields
`define ASF_CTRL_CLEAR      0
`define ASF_CTRL_OE         1
// status fields
`define ASF_ST_SPACE        0
`define ASF_ST_VALID        1
`define ASF_ST_HALF         2
`define ASF_ST_EDGE         3
`define ASF_ST_BUSY         4
`define ASF_ST_RDNEW        5
// timing, ns and derived cycles at 10 ns
`define ASF_CLK_NS          10
`define ASF_STROBE_HI_NS    20
`define ASF_STROBE_LO_NS    20
`define ASF_CLEAR_NS        40
`define ASF_FT_NS           40
`define ASF_PULSE_NS        5
`define ASF_CYC(ns)         (((ns) + `ASF_CLK_NS - 1) / `ASF_CLK_NS)
`endif

// >>> asf_pkg.sv
// asf_pkg.sv: types shared by the strobe fifo controller.
// assumes asf_map.svh supplies numbers; this holds types only.
`default_nettype none
package asf_pkg;
    typedef enum {ST_CLEAR, ST_IDLE, ST_WR_HI, ST_WR_LO, ST_RD_HI, ST_RD_LO} asf_state_type;
    typedef struct packed {
        logic       space;
        logic       valid;
        logic       half;
        logic       edgeLvl;
    } asf_flags_type;
endpackage : asf_pkg
`default_nettype wire

// >>> asf_host.sv
// asf_host.sv: APB-controlled host that drives a 64x5 strobe fifo by pins.
// assumes the fifo pins are asynchronous to clk; outputs change on clk.
`timescale 1ns/10ps
`default_nettype none
`include "asf_map.svh"
module asf_host
    import asf_pkg::*;
#(
    parameter int WIDTH = 5,
    parameter int HOLD_CYC = `ASF_CYC(`ASF_STROBE_HI_NS),
    parameter int LOW_CYC = `ASF_CYC(`ASF_STROBE_LO_NS),
    parameter int CLR_CYC = `ASF_CYC(`ASF_CLEAR_NS),
    parameter int HELD_CYC = `ASF_CYC(`ASF_FT_NS + `ASF_PULSE_NS)
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic             clkEn,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    output logic      [WIDTH-1:0] din,
    output logic                  writeStrobe,
    output logic                  readStrobe,
    output logic                  clear_n,
    output logic                  outEnable_n,
    input  wire logic [WIDTH-1:0] dout,
    input  wire logic             space_available,
    input  wire logic             word_valid,
    input  wire logic             half_level_flag,
    input  wire logic             edge_level_flag
);
    ////////////////////////////////////////////////////////////////////////
    asf_state_type      state;
    asf_flags_type      flagMeta;
    asf_flags_type      flagSync;
    logic [WIDTH-1:0]   doutMeta;
    logic [WIDTH-1:0]   doutSync;
    logic [7:0]         timer;
    logic               wrPend;
    logic               rdPend;
    logic               clrPend;
    logic [WIDTH-1:0]   rdWord;
    logic               rdNew;
    logic               oeCtrl;
    logic               apbWr;
    logic               apbRd;
    logic               mapped;
    logic               timerDone;

    // every fifo pin is asynchronous, so two flops before use
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            flagMeta <= '0;
            flagSync <= '0;
            doutMeta <= '0;
            doutSync <= '0;
        end else if (clkEn) begin
            flagMeta <= '{space_available, word_valid, half_level_flag, edge_level_flag};
            // a single fifo wide: its own flags already are the combined ones
            flagSync <= flagMeta;
            doutMeta <= dout;
            doutSync <= doutMeta;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // apb decode; slave answers in the access cycle, no wait states
    assign pready  = 1'b1;
    assign apbWr   = psel && penable && pwrite;
    assign apbRd   = psel && penable && !pwrite;
    assign mapped  = (paddr == `ASF_REG_CTRL) || (paddr == `ASF_REG_WDATA)
                  || (paddr == `ASF_REG_RDATA) || (paddr == `ASF_REG_STATUS);
    assign pslverr = psel && penable && !mapped;

    always_comb begin
        prdata = '0;
        unique case (paddr)
            `ASF_REG_CTRL: begin
                prdata[`ASF_CTRL_OE] = oeCtrl;
            end
            `ASF_REG_RDATA: begin
                prdata[WIDTH-1:0] = rdWord;
            end
            `ASF_REG_STATUS: begin
                prdata[`ASF_ST_SPACE] = flagSync.space;
                prdata[`ASF_ST_VALID] = flagSync.valid;
                prdata[`ASF_ST_HALF]  = flagSync.half;
                prdata[`ASF_ST_EDGE]  = flagSync.edgeLvl;
                prdata[`ASF_ST_BUSY]  = (state != ST_IDLE) || wrPend || rdPend || clrPend;
                prdata[`ASF_ST_RDNEW] = rdNew;
            end
            default: begin
                prdata = '0;
            end
        endcase
    end

    // software requests; a write or read request while one of its kind is pending is dropped
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wrPend  <= 1'b0;
            rdPend  <= 1'b0;
            clrPend <= 1'b0;
            oeCtrl  <= 1'b0;
        end else if (clkEn) begin
            if (apbWr && paddr == `ASF_REG_WDATA && !wrPend) begin
                wrPend <= 1'b1;
            end else if (state == ST_WR_HI && timerDone && flagSync.space == 1'b0) begin
                wrPend <= 1'b0;
            end
            if (apbWr && paddr == `ASF_REG_CTRL) begin
                oeCtrl <= pwdata[`ASF_CTRL_OE];
                if (pwdata[`ASF_CTRL_CLEAR]) begin
                    clrPend <= 1'b1;
                end
            end else if (state == ST_CLEAR && timerDone) begin
                clrPend <= 1'b0;
            end
            if (apbRd && paddr == `ASF_REG_RDATA && !rdPend) begin
                rdPend <= 1'b1;
            end else if (state == ST_RD_HI && timerDone) begin
                rdPend <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign timerDone = (timer == 8'h00);

    // strobe sequencer; starts in clear so the fifo is emptied after power-up
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= ST_CLEAR;
            timer <= 8'(CLR_CYC);
        end else if (clkEn) begin
            if (!timerDone) begin
                timer <= timer - 8'h01;
            end
            unique case (state)
                ST_CLEAR: begin
                    if (timerDone) begin
                        state <= ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    if (clrPend) begin
                        state <= ST_CLEAR;
                        timer <= 8'(CLR_CYC);
                    end else if (wrPend && flagSync.space) begin
                        state <= ST_WR_HI;
                        timer <= 8'(HELD_CYC);
                    end else if (rdPend && flagSync.valid) begin
                        state <= ST_RD_HI;
                        timer <= 8'(HOLD_CYC);
                    end
                end
                ST_WR_HI: begin
                    // drop the strobe only once the fifo has taken the word
                    if (timerDone && !flagSync.space) begin
                        state <= ST_WR_LO;
                        timer <= 8'(LOW_CYC);
                    end
                end
                ST_RD_HI: begin
                    if (timerDone) begin
                        state <= ST_RD_LO;
                        timer <= 8'(LOW_CYC);
                    end
                end
                ST_WR_LO, ST_RD_LO: begin
                    if (timerDone) begin
                        state <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // pins from flops; din stays put while the write strobe is high
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            din         <= '0;
            writeStrobe <= 1'b0;
            readStrobe  <= 1'b0;
            clear_n     <= 1'b0;
            outEnable_n <= 1'b1;
        end else if (clkEn) begin
            // load din when the write is taken, a full cycle before the strobe
            // rises, so data never changes as the strobe rises; a write taken in the first ST_WR_LO cycle moves din as the strobe falls
            if (apbWr && paddr == `ASF_REG_WDATA && !wrPend) begin
                din <= pwdata[WIDTH-1:0];
            end
            writeStrobe <= (state == ST_WR_HI) || (state == ST_IDLE && wrPend && flagSync.space
                           && !clrPend);
            readStrobe  <= (state == ST_RD_HI) || (state == ST_IDLE && !clrPend
                           && !(wrPend && flagSync.space) && rdPend && flagSync.valid);
            clear_n     <= !(state == ST_CLEAR && !timerDone) && !(state == ST_IDLE && clrPend);
            outEnable_n <= !oeCtrl;
        end
    end

    // capture dout before the read strobe; the word read is the one valid
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdWord <= '0;
            rdNew  <= 1'b0;
        end else if (clkEn) begin
            if (state == ST_IDLE && rdPend && flagSync.valid && !clrPend
                && !(wrPend && flagSync.space)) begin
                rdWord <= doutSync;
                rdNew  <= 1'b1;
            end else if (apbRd && paddr == `ASF_REG_STATUS) begin
                rdNew  <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    AST_CLEAR_HELD: assert property (@(posedge clk) disable iff (!resetn)
        $rose(clear_n) |-> $past(clear_n, 1) == 1'b0 && $past(clear_n, 2) == 1'b0)
        else $error("clear pulse too short");
    AST_NO_BOTH: assert property (@(posedge clk) disable iff (!resetn)
        !(writeStrobe && readStrobe))
        else $error("write and read strobes together");
    AST_STROBE_NOT_IN_CLEAR: assert property (@(posedge clk) disable iff (!resetn)
        !clear_n |-> !writeStrobe && !readStrobe)
        else $error("strobe during clear");
    AST_DIN_STABLE: assert property (@(posedge clk) disable iff (!resetn)
        clkEn && writeStrobe && $past(writeStrobe) |-> $stable(din))
        else $error("din changed under write strobe");
    AST_WR_HELD: assert property (@(posedge clk) disable iff (!resetn)
        clkEn && $rose(writeStrobe) ##1 clkEn |-> writeStrobe)
        else $error("write strobe released too early");
    AST_RD_LOW_GAP: assert property (@(posedge clk) disable iff (!resetn)
        clkEn && $fell(readStrobe) ##1 clkEn |-> !readStrobe)
        else $error("read strobe low time too short");
    AST_OE_FOLLOW: assert property (@(posedge clk) disable iff (!resetn)
        clkEn && $past(clkEn) |-> outEnable_n == !$past(oeCtrl))
        else $error("output enable not following control");
    AST_WR_NEEDS_SPACE: assert property (@(posedge clk) disable iff (!resetn)
        clkEn && $rose(writeStrobe) |-> $past(flagSync.space))
        else $error("write strobe without space");
endmodule : asf_host
`default_nettype wire

// >>> asf_fifo_model.sv
// asf_fifo_model.sv: behavioural 64x5 strobe fifo facing asf_host.
// assumes strobes and clear come from host registers; no clock here.
`timescale 1ns/10ps
`default_nettype none
module asf_fifo_model #(
    parameter int FT = 25
) (
    input  wire logic       writeStrobe,
    input  wire logic       readStrobe,
    input  wire logic       clear_n,
    input  wire logic       outEnable_n,
    input  wire logic [4:0] din,
    output wire logic [4:0] dout,
    output logic            space_available,
    output logic            word_valid,
    output wire logic       half_level_flag,
    output wire logic       edge_level_flag
);
    logic [4:0] mem [64];
    logic [4:0] q;
    logic [5:0] wp;
    logic [5:0] rp;
    int         cnt;
    logic       acc = 1'b0;
    logic       rseq = 1'b0;
    ////////////////////////////////////////////////////////////////////////
    // flags follow occupancy directly
    assign half_level_flag = cnt >= 32;
    assign edge_level_flag = cnt >= 56 || cnt <= 8;
    // a released bus must not look like a stale word, so show the inverse
    assign dout = outEnable_n ? ~q : q;
    // clear resets count, pointers, output word and flags; mem, acc and rseq keep their values
    always @(clear_n) if (!clear_n) begin
        cnt = 0;
        wp = 6'h0;
        rp = 6'h0;
        q = 5'h0;
        word_valid = 1'b0;
        space_available = 1'b1;
    end
    // write strobe rise: capture only with space
    always @(posedge writeStrobe) begin
        acc = space_available && clear_n;
        if (acc) begin
            mem[wp] = din;
            space_available = 1'b0;
        end
    end
    // write strobe fall: commit, maybe fall through
    always @(negedge writeStrobe) if (acc) begin
        wp++;
        cnt++;
        acc = 1'b0;
        space_available = cnt < 64;
        if (cnt == 1) begin
            q <= #FT mem[rp];
            word_valid <= #FT 1'b1;
        end
    end
    // read strobe rise: only a valid sequence counts
    always @(posedge readStrobe) begin
        rseq = word_valid;
        if (rseq) word_valid = 1'b0;
    end
    // read strobe fall: pop and present the next word
    always @(negedge readStrobe) if (rseq) begin
        rp++;
        cnt--;
        rseq = 1'b0;
        if (cnt == 63) space_available <= #FT 1'b1;
        if (cnt != 0) begin
            q <= #5 mem[rp];
            word_valid <= #5 1'b1;
        end
    end
endmodule : asf_fifo_model
`default_nettype wire

// >>> tb_asf_host.sv
// tb_asf_host.sv: self-checking bench, asf_host driving the fifo model.
// assumes the register map header and the host's default timing.
`timescale 1ns/10ps
`default_nettype none
`include "asf_map.svh"
module tb_asf_host;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic        clkEn = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd, w, held;
    logic        pready, pslverr, err;
    logic [4:0]  din, dout, lastCap;
    logic        writeStrobe, readStrobe, clear_n, outEnable_n;
    logic        space_available, word_valid, half_level_flag, edge_level_flag;
    int          num_errors = 0;
    int          cmp_count = 0;
    logic [31:0] seed = 32'h00001FA1;
    logic [4:0]  expQ[$];
    ////////////////////////////////////////////////////////////////////////
    asf_host DUT (.clk, .resetn, .clkEn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .din, .writeStrobe, .readStrobe, .clear_n,
        .outEnable_n, .dout, .space_available, .word_valid, .half_level_flag,
        .edge_level_flag);
    asf_fifo_model fifo (.writeStrobe, .readStrobe, .clear_n, .outEnable_n, .din,
        .dout, .space_available, .word_valid, .half_level_flag, .edge_level_flag);
    // 100 MHz clock
    always #5 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    // expected {edge, half, valid, space} from the reference queue
    function automatic logic [3:0] expSt();
        int m = expQ.size();
        return {m >= 56 || m <= 8, m >= 32, m > 0, m < 64};
    endfunction : expSt
    task automatic check(input logic [31:0] seen, exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %s %h not %h", $time, what, seen, exp);
        end
    endtask : check
    // one apb transfer; returns one edge after the access
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    // three idle status reads in a row outlast any strobe sequence
    task automatic settle(input string what);
        int idle = 0;
        while (idle < 3) begin
            apb(1'b0, `ASF_REG_STATUS, 32'h0);
            idle = (rd[`ASF_ST_BUSY] === 1'b0) ? idle + 1 : 0;
        end
        check(32'(rd[3:0]), 32'(expSt()), what);
    endtask : settle
    task automatic final_report();
        $display("errors %0d comparisons %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : final_report
    ////////////////////////////////////////////////////////////////////////
    // watchdog well past the expected run length
    initial begin
        #500000;
        num_errors++;
        final_report();
    end
    // main sequence
    initial begin
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        settle("reset state");
        check(32'(outEnable_n), 32'h1, "oe pin after reset");
        apb(1'b0, 12'h010, 32'h0);
        check({rd[31:1], err}, 32'h1, "unmapped");
        apb(1'b1, `ASF_REG_CTRL, 32'h2);
        apb(1'b0, `ASF_REG_CTRL, 32'h0);
        check(rd, 32'h2, "ctrl");
        check(32'(outEnable_n), 32'h0, "oe pin");
        // a frozen host must not take a bus write
        clkEn <= 1'b0;
        apb(1'b1, `ASF_REG_CTRL, 32'h0);
        clkEn <= 1'b1;
        apb(1'b0, `ASF_REG_CTRL, 32'h0);
        check(rd, 32'h2, "frozen ctrl");
        // one write at a time; a second one while pending would be dropped
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, `ASF_REG_WDATA, rnd());
            expQ.push_back(5'h0);
            settle("before clear");
        end
        apb(1'b1, `ASF_REG_CTRL, 32'h3);
        expQ.delete();
        settle("after clear");
        // fill to full
        for (int i = 0; i < 64; i++) begin
            w = rnd();
            apb(1'b1, `ASF_REG_WDATA, w);
            expQ.push_back(w[4:0]);
            settle("fill");
        end
        // full: one write waits for room, the next one is dropped
        held = rnd();
        apb(1'b1, `ASF_REG_WDATA, held);
        apb(1'b1, `ASF_REG_WDATA, rnd());
        repeat (20) @(posedge clk);
        apb(1'b0, `ASF_REG_STATUS, 32'h0);
        check(32'(rd[4:0]), 32'({1'b1, expSt()}), "write waits for space");
        // drain in order; the first read frees room for the waiting word
        for (int i = 0; i < 66; i++) begin
            apb(1'b0, `ASF_REG_RDATA, 32'h0);
            if (i > 0) check(rd, {27'h0, lastCap}, "word");
            if (expQ.size() > 0) lastCap = expQ.pop_front();
            if (i == 0) expQ.push_back(held[4:0]);
            if (i < 65) settle("drain");
        end
        repeat (20) @(posedge clk);
        apb(1'b0, `ASF_REG_STATUS, 32'h0);
        check(32'(rd[3:0]), 32'(expSt()), "empty read");
        final_report();
    end
endmodule : tb_asf_host
`default_nettype wire
